// ===== design/pfsb_bank.v
`timescale 1ns/100ps
`include "pfsb_regs.vh"

module pfsb_bank #(
  parameter NREG = 7,
  parameter DW   = 8
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  input  wire        wb_we_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire [7:0]  temp_fault_i,
  input  wire [7:0]  latch_timeout_alert_i,
  input  wire [7:0]  latch_timeout_fault_i,
  input  wire [7:0]  permfail_alert_first_i,
  input  wire [7:0]  permfail_status_first_i,
  input  wire [7:0]  permfail_alert_second_i,
  input  wire [7:0]  permfail_status_second_i,
  input  wire        ext_safety_fault_i,
  input  wire        ext_permfail_fault_i,
  output reg         any_permanent_fail_summary_o,
  output reg         any_safety_fault_summary_o,
  output reg         irq_o
);

  // ----------------------------------------------------------------
  // Packed flag inputs and implemented-bit masks
  // ----------------------------------------------------------------
  wire [NREG*DW-1:0] raw_flat;
  wire [NREG*DW-1:0] valid_flat;
  wire [NREG*DW-1:0] rep_flat;
  wire [NREG*DW-1:0] ena_flat;
  wire [NREG-1:0]    evt;
  wire               bus_req;
  wire               bus_wr;
  wire [NREG-1:0]    w1c_bits;
  wire               safety_any;
  wire               permfail_any;

  // Input bit positions follow the register layouts one to one
  assign raw_flat = {permfail_status_second_i,
                     permfail_alert_second_i,
                     permfail_status_first_i,
                     permfail_alert_first_i,
                     latch_timeout_fault_i,
                     latch_timeout_alert_i,
                     temp_fault_i};

  assign valid_flat = {`PFSB_MASK_PF_2,
                       `PFSB_MASK_PF_2,
                       `PFSB_MASK_PF_1,
                       `PFSB_MASK_PF_1,
                       `PFSB_MASK_LT_FAULT,
                       `PFSB_MASK_LT_ALERT,
                       `PFSB_MASK_TEMP_FAULT};

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Ack follows one cycle after the strobe and drops for one cycle,
  // so a held request is answered again only every other cycle.
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
  assign w1c_bits = (bus_wr && (wb_adr_i == `PFSB_OFF_INT_STATUS)) ?
                    wb_dat_i[NREG-1:0] : {NREG{1'b0}};

  // ----------------------------------------------------------------
  // Per-register enable, report and change-event logic
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi = gi + 1) begin : g_flag
      reg  [DW-1:0] ena_reg;
      reg  [DW-1:0] prev_reg;
      wire [DW-1:0] valid_bits;
      wire [DW-1:0] ena_eff;
      wire [7:0]    ena_off;
      localparam integer ENA_OFF_INT = `PFSB_ENA_BASE + gi * `PFSB_STRIDE;

      assign valid_bits = valid_flat[gi*DW +: DW];
      assign ena_off    = ENA_OFF_INT[7:0];

      // The suspend indication is a state, not a protection, so it is
      // never gated by the enable mask
      if (gi == `PFSB_IDX_LT_ALERT) begin : g_susp
        assign ena_eff = ena_reg | ({{(DW-1){1'b0}}, 1'b1} << `PFSB_BIT_SUSPENDED);
      end else begin : g_norm
        assign ena_eff = ena_reg;
      end

      // Only implemented flags that are enabled, or the suspend bit, reach the register
      assign rep_flat[gi*DW +: DW] = raw_flat[gi*DW +: DW] & ena_eff & valid_bits;
      assign ena_flat[gi*DW +: DW] = ena_reg;

      // A newly set flag in this register raises its interrupt event
      assign evt[gi] = |(rep_flat[gi*DW +: DW] & ~prev_reg);

      always @(posedge clk_i) begin
        if (rst_i) begin
          ena_reg  <= valid_bits;
          prev_reg <= {DW{1'b0}};
        end else begin
          prev_reg <= rep_flat[gi*DW +: DW];
          if (bus_wr && (wb_adr_i == ena_off)) begin
            ena_reg <= wb_dat_i[DW-1:0] & valid_bits;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Battery status summary
  // ----------------------------------------------------------------
  assign safety_any = (|rep_flat[`PFSB_IDX_TEMP_FAULT*DW +: DW]) |
                      (|rep_flat[`PFSB_IDX_LT_FAULT*DW +: DW]) |
                      ext_safety_fault_i;
  assign permfail_any = (|rep_flat[`PFSB_IDX_PF_STATUS_1*DW +: DW]) |
                        (|rep_flat[`PFSB_IDX_PF_STATUS_2*DW +: DW]) |
                        ext_permfail_fault_i;

  always @(posedge clk_i) begin
    if (rst_i) begin
      any_permanent_fail_summary_o <= 1'b0;
      any_safety_fault_summary_o   <= 1'b0;
    end else begin
      any_permanent_fail_summary_o <= permfail_any;
      any_safety_fault_summary_o   <= safety_any;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  reg  [NREG-1:0] int_status_reg;
  reg  [NREG-1:0] int_mask_reg;
  wire [NREG-1:0] int_status_next;

  // A new event in the clearing cycle survives the write-one-to-clear
  assign int_status_next = (int_status_reg & ~w1c_bits) | evt;

  always @(posedge clk_i) begin
    if (rst_i) begin
      int_status_reg <= `PFSB_RST_INT_STATUS;
      int_mask_reg   <= `PFSB_RST_INT_MASK;
      irq_o          <= 1'b0;
    end else begin
      int_status_reg <= int_status_next;
      if (bus_wr && (wb_adr_i == `PFSB_OFF_INT_MASK)) begin
        int_mask_reg <= wb_dat_i[NREG-1:0];
      end
      irq_o <= |(int_status_next & int_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Read mux; unmapped addresses read zero and still ack
  // ----------------------------------------------------------------
  reg [31:0] rd_data;
  integer    ri;

  always @* begin
    rd_data = `PFSB_RST_DATA;
    for (ri = 0; ri < NREG; ri = ri + 1) begin
      if (wb_adr_i == (`PFSB_FLAG_BASE + ri[7:0] * `PFSB_STRIDE)) begin
        rd_data[DW-1:0] = rep_flat[ri*DW +: DW];
      end
      if (wb_adr_i == (`PFSB_ENA_BASE + ri[7:0] * `PFSB_STRIDE)) begin
        rd_data[DW-1:0] = ena_flat[ri*DW +: DW];
      end
    end
    if (wb_adr_i == `PFSB_OFF_SUMMARY) begin
      rd_data[`PFSB_SUM_PF_BIT] = permfail_any;
      rd_data[`PFSB_SUM_SS_BIT] = safety_any;
    end
    if (wb_adr_i == `PFSB_OFF_INT_STATUS) begin
      rd_data[NREG-1:0] = int_status_reg;
    end
    if (wb_adr_i == `PFSB_OFF_INT_MASK) begin
      rd_data[NREG-1:0] = int_mask_reg;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `PFSB_RST_DATA;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= rd_data;
      end
    end
  end

endmodule // pfsb_bank

// ===== design/pfsb_regs.vh
`ifndef PFSB_REGS_VH
`define PFSB_REGS_VH

// ----------------------------------------------------------------
// Register map (byte addresses, 32-bit aligned words)
// ----------------------------------------------------------------
`define PFSB_ADR_W            8
`define PFSB_STRIDE           8'h04
`define PFSB_FLAG_BASE        8'h00
`define PFSB_OFF_TEMP_FAULT   8'h00
`define PFSB_OFF_LT_ALERT     8'h04
`define PFSB_OFF_LT_FAULT     8'h08
`define PFSB_OFF_PF_ALERT_1   8'h0C
`define PFSB_OFF_PF_STATUS_1  8'h10
`define PFSB_OFF_PF_ALERT_2   8'h14
`define PFSB_OFF_PF_STATUS_2  8'h18
`define PFSB_OFF_SUMMARY      8'h1C
`define PFSB_ENA_BASE         8'h20
`define PFSB_OFF_INT_STATUS   8'h40
`define PFSB_OFF_INT_MASK     8'h44

// ----------------------------------------------------------------
// Flag register index in the packed flag vector
// ----------------------------------------------------------------
`define PFSB_IDX_TEMP_FAULT   0
`define PFSB_IDX_LT_ALERT     1
`define PFSB_IDX_LT_FAULT     2
`define PFSB_IDX_PF_ALERT_1   3
`define PFSB_IDX_PF_STATUS_1  4
`define PFSB_IDX_PF_ALERT_2   5
`define PFSB_IDX_PF_STATUS_2  6

// ----------------------------------------------------------------
// Implemented-bit masks; reserved positions read zero
// ----------------------------------------------------------------
`define PFSB_MASK_TEMP_FAULT  8'hF7
`define PFSB_MASK_LT_ALERT    8'hF8
`define PFSB_MASK_LT_FAULT    8'hF6
`define PFSB_MASK_PF_1        8'hDF
`define PFSB_MASK_PF_2        8'h9F
`define PFSB_BIT_SUSPENDED    3

// ----------------------------------------------------------------
// Summary word and reset values
// ----------------------------------------------------------------
`define PFSB_SUM_PF_BIT       12
`define PFSB_SUM_SS_BIT       11
`define PFSB_RST_INT_STATUS   7'h00
`define PFSB_RST_INT_MASK     7'h00
`define PFSB_RST_DATA         32'h00000000

`endif

// ===== verif/pfsb_chk.sv
`timescale 1ns/100ps
module pfsb_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic        wb_we_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [7:0]  temp_fault_i,
  input wire logic [7:0]  latch_timeout_alert_i,
  input wire logic [7:0]  latch_timeout_fault_i,
  input wire logic [7:0]  permfail_status_first_i,
  input wire logic [7:0]  permfail_status_second_i,
  input wire logic        ext_safety_fault_i,
  input wire logic        ext_permfail_fault_i,
  input wire logic        any_permanent_fail_summary_o,
  input wire logic        any_safety_fault_summary_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence rd_s;
    wb_ack_o && !$past(wb_we_i);
  endsequence
  bus_answer_a: assert property (req_s |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack missing or longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  dat_hold_a: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved outside a read ack");
  unmapped_zero_a: assert property (rd_s ##0 $past(wb_adr_i) >= 8'h48 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (rd_s ##0 $past(wb_adr_i) != 8'h1C |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  temp_only_a: assert property (rd_s ##0 $past(wb_adr_i) == 8'h00
    |-> (wb_dat_o[7:0] & ~($past(temp_fault_i) & 8'hF7)) == 8'h00)
    else $error("temperature bit set without fault");
  lt_only_a: assert property (rd_s ##0 $past(wb_adr_i) == 8'h08
    |-> (wb_dat_o[7:0] & ~($past(latch_timeout_fault_i) & 8'hF6)) == 8'h00)
    else $error("latch status bit set without fault");
  susp_pass_a: assert property (rd_s ##0 $past(wb_adr_i) == 8'h04
    |-> wb_dat_o[3] == $past(latch_timeout_alert_i[3]))
    else $error("suspend bit does not follow its input");
  pf_clear_a: assert property (((permfail_status_first_i & 8'hDF) == 8'h00
    && (permfail_status_second_i & 8'h9F) == 8'h00 && !ext_permfail_fault_i)
    |=> !any_permanent_fail_summary_o) else $error("fail summary without cause");
  ss_clear_a: assert property (((temp_fault_i & 8'hF7) == 8'h00
    && (latch_timeout_fault_i & 8'hF6) == 8'h00 && !ext_safety_fault_i)
    |=> !any_safety_fault_summary_o) else $error("safety summary without cause");
endmodule // pfsb_chk

bind pfsb_bank pfsb_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
  .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .temp_fault_i(temp_fault_i),
  .latch_timeout_alert_i(latch_timeout_alert_i),
  .latch_timeout_fault_i(latch_timeout_fault_i),
  .permfail_status_first_i(permfail_status_first_i),
  .permfail_status_second_i(permfail_status_second_i),
  .ext_safety_fault_i(ext_safety_fault_i), .ext_permfail_fault_i(ext_permfail_fault_i),
  .any_permanent_fail_summary_o(any_permanent_fail_summary_o),
  .any_safety_fault_summary_o(any_safety_fault_summary_o));

// ===== verif/pfsb_host.sv
`timescale 1ns/100ps
module pfsb_host (
  input  wire logic        clk_i,
  input  wire logic [31:0] dat_i,
  input  wire logic        ack_i,
  output logic      [7:0]  adr_o = 8'h00,
  output logic      [31:0] dat_o = 32'h0,
  output logic      [3:0]  sel_o = 4'h0,
  output logic             we_o  = 1'b0,
  output logic             cyc_o = 1'b0,
  output logic             stb_o = 1'b0
);
  // Holds the request until ack is sampled; caller owns the timeout verdict
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s,
            output logic [31:0] q, output bit ok);
    int n;
    n = 0;
    @(posedge clk_i);
    adr_o <= a;
    dat_o <= d;
    we_o  <= w;
    sel_o <= s;
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 50);
    q = dat_i;
    ok = (ack_i === 1'b1);
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
  endtask
endmodule // pfsb_host

// ===== verif/pfsb_bank_test.sv
`timescale 1ns/100ps
`include "pfsb_regs.vh"
module pfsb_bank_test;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  fl [7] = '{default: 8'h00};
  logic        ext_ss = 1'b0;
  logic        ext_pf = 1'b0;
  logic [7:0]  adr;
  logic [31:0] wd, rd, q;
  logic [3:0]  sel;
  logic        we, cyc, stb, ack, pf_o, ss_o, irq;
  logic [7:0]  msk [7] = '{`PFSB_MASK_TEMP_FAULT, `PFSB_MASK_LT_ALERT, `PFSB_MASK_LT_FAULT,
                          `PFSB_MASK_PF_1, `PFSB_MASK_PF_1, `PFSB_MASK_PF_2, `PFSB_MASK_PF_2};
  int          error_cnt = 0;
  int          check_count = 0;
  bit          ok;
  logic [3:0]  bsel = 4'hF;
  always #50 clk_i = ~clk_i;
  pfsb_host host (.clk_i(clk_i), .dat_i(rd), .ack_i(ack), .adr_o(adr), .dat_o(wd),
    .sel_o(sel), .we_o(we), .cyc_o(cyc), .stb_o(stb));
  pfsb_bank dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(sel),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rd), .wb_ack_o(ack),
    .temp_fault_i(fl[0]), .latch_timeout_alert_i(fl[1]), .latch_timeout_fault_i(fl[2]),
    .permfail_alert_first_i(fl[3]), .permfail_status_first_i(fl[4]),
    .permfail_alert_second_i(fl[5]), .permfail_status_second_i(fl[6]),
    .ext_safety_fault_i(ext_ss), .ext_permfail_fault_i(ext_pf),
    .any_permanent_fail_summary_o(pf_o), .any_safety_fault_summary_o(ss_o), .irq_o(irq));
  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task conclude();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    host.xfer(a, w, d, bsel, q, ok);
    if (!ok) begin
      error_cnt++;
      conclude();
    end
  endtask
  task setf(input logic [7:0] v);
    @(posedge clk_i);
    foreach (fl[i]) fl[i] <= v;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    setf(8'hFF);
    for (int i = 0; i < 7; i++) begin
      bus(8'(4 * i), 1'b0, 32'h0);
      chk("flag_set", {24'h0, msk[i]}, q);
    end
    bus(`PFSB_OFF_SUMMARY, 1'b0, 32'h0);
    chk("summary", 32'h00001800, q);
    chk("sum_ports", 32'h3, {30'h0, pf_o, ss_o});
    $display("test flags_set done");
    for (int i = 0; i < 7; i++) bus(8'h20 + 8'(4 * i), 1'b1, 32'h0);
    for (int i = 0; i < 7; i++) begin
      bus(8'(4 * i), 1'b0, 32'h0);
      chk("flag_off", (i == 1) ? 32'h08 : 32'h0, q);
    end
    bus(`PFSB_OFF_SUMMARY, 1'b0, 32'h0);
    chk("summary_off", 32'h0, q);
    chk("sum_ports_off", 32'h0, {30'h0, pf_o, ss_o});
    $display("test enables done");
    for (int i = 0; i < 7; i++) bus(8'h20 + 8'(4 * i), 1'b1, 32'hFF);
    setf(8'h00);
    for (int i = 0; i < 7; i++) begin
      bus(8'(4 * i), 1'b0, 32'h0);
      chk("flag_clear", 32'h0, q);
    end
    bus(`PFSB_OFF_INT_MASK, 1'b1, 32'h10);
    bus(`PFSB_OFF_INT_STATUS, 1'b1, 32'h7F);
    chk("irq_idle", 32'h0, {31'h0, irq});
    @(posedge clk_i);
    fl[4] <= 8'h01;
    fl[3] <= 8'h01;
    repeat (2) @(posedge clk_i);
    chk("irq_on", 32'h3, {30'h0, irq, pf_o});
    bus(`PFSB_OFF_INT_STATUS, 1'b0, 32'h0);
    chk("int_status", 32'h18, q);
    bus(`PFSB_OFF_INT_STATUS, 1'b1, 32'h10);
    bus(`PFSB_OFF_INT_STATUS, 1'b0, 32'h0);
    chk("int_w1c", 32'h08, q);
    chk("irq_off", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    setf(8'h00);
    ext_pf <= 1'b1;
    bus(8'hFC, 1'b1, 32'hFFFFFFFF);
    bus(8'hFC, 1'b0, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(`PFSB_OFF_SUMMARY, 1'b1, 32'h0);
    bus(`PFSB_OFF_SUMMARY, 1'b0, 32'h0);
    chk("ext_pf", 32'h00001000, q);
    ext_pf <= 1'b0;
    ext_ss <= 1'b1;
    bus(`PFSB_OFF_SUMMARY, 1'b0, 32'h0);
    chk("ext_ss", 32'h00000800, q);
    chk("ext_ports", 32'h1, {30'h0, pf_o, ss_o});
    bsel = 4'hE;
    bus(`PFSB_ENA_BASE, 1'b1, 32'h0);
    bsel = 4'hF;
    bus(`PFSB_ENA_BASE, 1'b0, 32'h0);
    chk("sel_ignored", {24'h0, `PFSB_MASK_TEMP_FAULT}, q);
    $display("test misc done");
    conclude();
  end
  initial begin
    #2000000;
    error_cnt++;
    conclude();
  end
endmodule // pfsb_bank_test
